// file: bankmem_defs.svh
// Address map, field positions and codes for the banked data memory unit
`ifndef BANKMEM_DEFS_SVH
`define BANKMEM_DEFS_SVH

// Data memory geometry
`define DATA_W 8
`define IDX_W 9
`define MEM_DEPTH 512
`define DATA_ZERO 8'h00

// Special function addresses, shared by both banks except ADR_EEC, which exists in bank 1 only
`define ADR_IND0 8'h00
`define ADR_MP0 8'h01
`define ADR_IND1 8'h02
`define ADR_MP1 8'h03
`define ADR_BANK 8'h04
`define ADR_PROT 8'h08
`define ADR_EEC 8'h40
`define GP_FLAG_BIT 7

// Storage index of the bank register and its implemented bit
`define IDX_BANK 9'h004
`define BANK_MASK 8'h01
`define BANK_BIT 0

// APB byte address split: word index in bits 9..2
`define DADR_LSB 2
`define DADR_MSB 9
`define ADDR_HI_LSB 10
`define ADDR_HI_ZERO 22'h000000
`define ADDR_LO_ZERO 2'h0
`define RDATA_PAD 24'h000000

// Write data fields: operation code and bit number
`define OP_LSB 12
`define OP_MSB 14
`define BIT_LSB 8
`define BIT_MSB 10
`define OP_WRITE 3'h0
`define OP_SET 3'h1
`define OP_CLR 3'h2
`define OP_INC 3'h3
`define OP_DEC 3'h4
`define BYTE_ONE 8'h01
`define BIT_ONE 8'h01

// Programming link: bits per byte, MSB first
`define PROG_LAST 3'h7
`define PROG_ONE 3'h1

`endif

// file: bankmem_pkg.sv
// Types shared by the banked data memory unit
`include "bankmem_defs.svh"
package bankmem_pkg;

  // Resolved target of one data memory access
  typedef struct packed {
    logic [`IDX_W-1:0] idx;
    logic void_acc;
    logic unused;
    logic prot;
  } target_t;

  // Programming link phases
  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_RX,
    PROG_TX
  } prog_state_t;

endpackage

// file: bankmem.sv
// Banked data memory with direct and indirect addressing behind an APB slave
//
// Behaviour
// - Volatile array of 8-bit words from zero
// - Special registers low, general area above them
// - Two banks; pointer-one bank from bank register
// - Bank changes only by writing bank register
// - Special registers shared across both banks
// - EEPROM control at 40H only in bank 1
// - Protected register ignores program writes
// - General area fully readable and writable
// - Bit set and clear keep other bits
// - Port access goes to location in pointer
// - Port read through port returns zero
// - Port write through port is discarded
// - Pointers are real, incrementable, decrementable storage
// - Pointer zero always targets bank 0
// - Pointer one targets currently selected bank
// - Direct addresses reach bank 0 only
// - Serial data one bidirectional pin, external clock
// - Bank bit 0 selects bank, upper zero
// - Reset clears bank except watchdog idle reset
//
// Added by the designer: the APB interface to the registers.
`include "bankmem_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bankmem
  import bankmem_pkg::*;
(
  // Clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // System reset request from the core, same clock
  input wire logic reset_req,
  input wire logic reset_is_wdt_idle,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // In-circuit programming pins
  input wire logic external_reset_pin_n,
  input wire logic program_clock_pin,
  input wire logic program_data_pin_i,
  output logic program_data_pin_o,
  output logic program_data_pin_oe,
  // Programming mode flag for the rest of the chip
  output logic prog_mode
);

  // Storage and registered outputs
  logic [`DATA_W-1:0] mem_ff [0:`MEM_DEPTH-1];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Pin synchronisers and programming link state
  logic rst_pin_s1_ff;
  logic rst_pin_s2_ff;
  logic clk_pin_s1_ff;
  logic clk_pin_s2_ff;
  logic clk_pin_s3_ff;
  logic dat_pin_s1_ff;
  logic dat_pin_s2_ff;
  prog_state_t prog_state_ff;
  logic [2:0] prog_cnt_ff;
  logic [`DATA_W-1:0] prog_shift_ff;
  logic [`DATA_W-1:0] prog_byte_ff;
  logic data_o_ff;
  logic data_oe_ff;
  logic prog_mode_ff;

  // Decode wires
  wire logic [`DATA_W-1:0] dir_addr;
  wire logic addr_ok;
  wire logic is_ind0;
  wire logic is_ind1;
  wire logic via_ind;
  wire logic bank_sel;
  wire logic [`DATA_W-1:0] mp0_val;
  wire logic [`DATA_W-1:0] mp1_val;
  wire logic [`DATA_W-1:0] eff_addr;
  wire logic eff_bank;
  wire logic gp_hit;
  wire logic eec_hit;
  wire logic bank_reg_hit;
  wire target_t tgt;
  wire logic [`DATA_W-1:0] rd_val;
  wire logic [2:0] op;
  wire logic [`DATA_W-1:0] bit_mask;
  wire logic [`DATA_W-1:0] op_val;
  wire logic [`DATA_W-1:0] wr_val;
  wire logic access_first;
  wire logic access_done;
  wire logic wr_fire;
  wire logic acc_err;
  wire logic bank_clr;
  wire logic prog_now;
  wire logic clk_rise;
  wire logic clk_fall;

  // Byte address to data memory word address
  assign dir_addr = paddr[`DADR_MSB:`DADR_LSB];
  // Upper and lane bits must be zero so no alias of a slot reaches the array
  assign addr_ok = (paddr[31:`ADDR_HI_LSB] == `ADDR_HI_ZERO) && (paddr[`DADR_LSB-1:0] == `ADDR_LO_ZERO);

  // Pointers and bank bit live in the shared special area
  assign mp0_val = mem_ff[{1'b0, `ADR_MP0}];
  assign mp1_val = mem_ff[{1'b0, `ADR_MP1}];
  assign bank_sel = mem_ff[`IDX_BANK][`BANK_BIT];

  // Indirect ports swap in the paired pointer as the address
  assign is_ind0 = (dir_addr == `ADR_IND0);
  assign is_ind1 = (dir_addr == `ADR_IND1);
  assign via_ind = is_ind0 | is_ind1;
  assign eff_addr = is_ind0 ? mp0_val : (is_ind1 ? mp1_val : dir_addr);
  // Only pointer one follows the bank bit; all else sees bank 0
  assign eff_bank = is_ind1 ? bank_sel : 1'b0;

  // General area is banked; special area is shared except the EEPROM slot
  assign gp_hit = eff_addr[`GP_FLAG_BIT];
  // The EEPROM control slot is the one special address that is banked
  assign eec_hit = (eff_addr == `ADR_EEC);
  assign bank_reg_hit = (tgt.idx == `IDX_BANK);
  assign tgt.idx = (gp_hit || (eec_hit && eff_bank)) ? {eff_bank, eff_addr} : {1'b0, eff_addr};
  assign tgt.unused = eec_hit && !eff_bank;
  assign tgt.void_acc = via_ind && ((eff_addr == `ADR_IND0) || (eff_addr == `ADR_IND1));
  // Read-only slot shows the last programming byte; writes to it vanish
  assign tgt.prot = (eff_addr == `ADR_PROT);

  // Read path: ports read through ports and unused slots give zero
  // Unused slots read zero rather than whatever storage sits behind them
  assign rd_val = (tgt.void_acc || tgt.unused) ? `DATA_ZERO
                : (tgt.prot ? prog_byte_ff : mem_ff[tgt.idx]);

  // Read-modify-write operations act on the resolved location
  assign op = pwdata[`OP_MSB:`OP_LSB];
  assign bit_mask = `BIT_ONE << pwdata[`BIT_MSB:`BIT_LSB];
  assign op_val = (op == `OP_SET) ? (rd_val | bit_mask)
                : (op == `OP_CLR) ? (rd_val & ~bit_mask)
                : (op == `OP_INC) ? (rd_val + `BYTE_ONE)
                : (op == `OP_DEC) ? (rd_val - `BYTE_ONE)
                : pwdata[`DATA_W-1:0];
  // Bank register keeps only its select bit
  assign wr_val = bank_reg_hit ? (op_val & `BANK_MASK) : op_val;

  // APB phases: first access edge answers, second edge completes
  assign access_first = psel && penable && !pready_ff;
  assign access_done = psel && penable && pready_ff;
  // Error is decided at the first access edge and stands with the answer
  assign acc_err = !addr_ok || (pwrite && prog_now);
  // Writes land on the completing edge; protected, void and unused targets drop them
  assign wr_fire = access_done && pwrite && addr_ok && !prog_now
                && !tgt.void_acc && !tgt.unused && !tgt.prot;

  // Watchdog reset from idle must not disturb the bank choice
  // Limitation: the core flags that reset kind; this block cannot tell it apart
  assign bank_clr = reset_req && !reset_is_wdt_idle;

  // Writes are refused while the programmer holds the pin low, so the core
  // never races the programmer for the same storage
  // Programming mode follows the synchronised reset pin
  assign prog_now = !rst_pin_s2_ff;
  assign clk_rise = clk_pin_s2_ff && !clk_pin_s3_ff;
  assign clk_fall = !clk_pin_s2_ff && clk_pin_s3_ff;

  // One always block per storage byte; no reset value is promised for
  // volatile memory but zeroing keeps reads defined in simulation
  genvar gi;
  generate
    for (gi = 0; gi < `MEM_DEPTH; gi = gi + 1)
    begin : g_mem
      // Slot number at the width of the resolved index
      localparam logic [`IDX_W-1:0] slot_idx = `IDX_W'(gi);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mem_ff[gi] <= `DATA_ZERO;
        end
        else if (clk_en)
        begin
          // Reset request beats a write to the bank register
          if ((slot_idx == `IDX_BANK) && bank_clr)
          begin
            mem_ff[gi] <= `DATA_ZERO;
          end
          else if (wr_fire && (tgt.idx == slot_idx))
          begin
            mem_ff[gi] <= wr_val;
          end
        end
      end
    end
  endgenerate

  // APB answer: one wait state, read data captured at the first access edge
  // The wait state gives the resolved target a full cycle to settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= {`RDATA_PAD, `DATA_ZERO};
      pslverr_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (access_first)
      begin
        pready_ff <= 1'b1;
        prdata_ff <= {`RDATA_PAD, (addr_ok ? rd_val : `DATA_ZERO)};
        pslverr_ff <= acc_err;
      end
      else
      begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_pin_s1_ff <= 1'b1;
      rst_pin_s2_ff <= 1'b1;
      clk_pin_s1_ff <= 1'b0;
      clk_pin_s2_ff <= 1'b0;
      clk_pin_s3_ff <= 1'b0;
      dat_pin_s1_ff <= 1'b0;
      dat_pin_s2_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      rst_pin_s1_ff <= external_reset_pin_n;
      rst_pin_s2_ff <= rst_pin_s1_ff;
      clk_pin_s1_ff <= program_clock_pin;
      clk_pin_s2_ff <= clk_pin_s1_ff;
      clk_pin_s3_ff <= clk_pin_s2_ff;
      dat_pin_s1_ff <= program_data_pin_i;
      dat_pin_s2_ff <= dat_pin_s1_ff;
    end
  end

  // Programming link: receive a byte on rising clock, echo it on falling;
  // the full protocol is not modelled, only the pin turnaround
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_state_ff <= PROG_IDLE;
      prog_cnt_ff <= 3'h0;
      prog_shift_ff <= `DATA_ZERO;
      prog_byte_ff <= `DATA_ZERO;
      data_o_ff <= 1'b0;
      data_oe_ff <= 1'b0;
      prog_mode_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      prog_mode_ff <= prog_now;
      if (!prog_now)
      begin
        // Pins go back to the port logic as soon as reset is released
        prog_state_ff <= PROG_IDLE;
        prog_cnt_ff <= 3'h0;
        data_oe_ff <= 1'b0;
        data_o_ff <= 1'b0;
      end
      else
      begin
        case (prog_state_ff)
          PROG_IDLE:
          begin
            prog_state_ff <= PROG_RX;
            prog_cnt_ff <= 3'h0;
            data_oe_ff <= 1'b0;
          end
          PROG_RX:
          begin
            if (clk_rise)
            begin
              prog_shift_ff <= {prog_shift_ff[`DATA_W-2:0], dat_pin_s2_ff};
              prog_cnt_ff <= prog_cnt_ff + `PROG_ONE;
              if (prog_cnt_ff == `PROG_LAST)
              begin
                prog_byte_ff <= {prog_shift_ff[`DATA_W-2:0], dat_pin_s2_ff};
                prog_shift_ff <= {prog_shift_ff[`DATA_W-2:0], dat_pin_s2_ff};
                data_o_ff <= prog_shift_ff[`DATA_W-2];
                data_oe_ff <= 1'b1;
                prog_cnt_ff <= 3'h0;
                prog_state_ff <= PROG_TX;
              end
            end
          end
          PROG_TX:
          begin
            if (clk_fall)
            begin
              prog_cnt_ff <= prog_cnt_ff + `PROG_ONE;
              prog_shift_ff <= {prog_shift_ff[`DATA_W-2:0], 1'b0};
              data_o_ff <= prog_shift_ff[`DATA_W-2];
              if (prog_cnt_ff == `PROG_LAST)
              begin
                // Release the pin before the programmer drives again
                data_oe_ff <= 1'b0;
                data_o_ff <= 1'b0;
                prog_cnt_ff <= 3'h0;
                prog_state_ff <= PROG_RX;
              end
            end
          end
          default:
          begin
            prog_state_ff <= PROG_IDLE;
            data_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  // No logic follows the flip-flops, so pins and bus stay glitch free
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign program_data_pin_o = data_o_ff;
  assign program_data_pin_oe = data_oe_ff;
  assign prog_mode = prog_mode_ff;

endmodule

`default_nettype wire

// file: bankmem_props.sv
// Port checker for the banked data memory unit
`timescale 1ns/10ps
`default_nettype none
module bankmem_props (
  // Clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Programming
  input wire logic external_reset_pin_n,
  input wire logic prog_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // One wait state, one-cycle answer, only inside an access
  property p_wait; psel && penable && !pready && clk_en |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late answer");
  property p_pulse; pready && clk_en |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_pad; pready |-> psel && penable && prdata[31:8] == 24'h0; endproperty
  a_pad: assert property (p_pad) else $error("bad answer");
  // Misaligned or out-of-range address is refused and reads zero
  property p_bad;
    pready && (paddr[1:0] != 2'h0 || paddr[31:10] != 22'h0) |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_bad: assert property (p_bad) else $error("bad address taken");
  property p_bank; pready && !pwrite && paddr == 32'h10 |-> prdata[7:1] == 7'h0; endproperty
  a_bank: assert property (p_bank) else $error("bank upper bits");
  // Mode follows the pin through a short synchroniser
  property p_enter; $fell(external_reset_pin_n) |-> ##[1:4] prog_mode; endproperty
  a_enter: assert property (p_enter) else $error("no prog mode");
  property p_leave; external_reset_pin_n [*6] |-> !prog_mode; endproperty
  a_leave: assert property (p_leave) else $error("stuck in prog mode");
  property p_lock; pready && pwrite && prog_mode && $past(prog_mode) |-> pslverr; endproperty
  a_lock: assert property (p_lock) else $error("write in prog mode");
endmodule
bind bankmem bankmem_props u_props (.*);
`default_nettype wire

// file: prog_model.sv
// Programmer model on the in-circuit programming pins
`timescale 1ns/10ps
`default_nettype none
module prog_model (
  // Pacing clock and shared data line
  input wire logic pclk,
  input wire logic program_data_pin_i,
  // Pins the programmer drives
  output logic external_reset_pin_n,
  output logic program_clock_pin,
  output logic data_drv
);
  // Idle: reset pin released, clock standing low
  initial
  begin
    external_reset_pin_n = 1'b1;
    program_clock_pin = 1'b0;
    data_drv = 1'b0;
  end
  // Byte out MSB first; half periods far above the sync delay
  task automatic frame(input logic [7:0] b, output logic [7:0] echo);
    external_reset_pin_n <= 1'b0;
    for (int k = 7; k >= 0; k--)
    begin
      data_drv <= b[k];
      repeat (8) @(posedge pclk);
      program_clock_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      if (k > 0)
        program_clock_pin <= 1'b0;
    end
    // Released line shows the inverse, never a stale copy
    data_drv <= ~b[0];
    for (int k = 7; k >= 0; k--)
    begin
      repeat (8) @(posedge pclk);
      echo[k] = program_data_pin_i;
      program_clock_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      if (k > 0)
        program_clock_pin <= 1'b1;
    end
    external_reset_pin_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Directed bench for the banked data memory unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Pins of the unit and of the programmer
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, reset_req = 1'b0, reset_is_wdt_idle = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, erv;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
  logic external_reset_pin_n, program_clock_pin, data_drv, program_data_pin_o, program_data_pin_oe, prog_mode;
  logic [7:0] echo;
  int n_fail = 0, total_checks = 0;
  wire program_data_pin_i;
  // Unit drives the shared line only while enabled
  assign program_data_pin_i = program_data_pin_oe ? program_data_pin_o : data_drv;
  always #50 pclk = ~pclk;
  bankmem dut (.*);
  prog_model prog (.*);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; the hang guard bounds the wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, {22'h0, a, 2'h0}, {16'h0, d});
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, {22'h0, a, 2'h0}, 32'h0);
    chk(rdv, {24'h0, e});
  endtask
  // Core reset request, maybe a watchdog wake
  task automatic req(input logic wdt);
    @(posedge pclk);
    reset_req <= 1'b1;
    reset_is_wdt_idle <= wdt;
    @(posedge pclk);
    reset_req <= 1'b0;
  endtask
  // Hang guard
  initial
  begin
    repeat (8000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    ck(8'h04, 8'h00);
    wr(8'h04, 16'h00ff);
    ck(8'h04, 8'h01);
    wr(8'h80, 16'h005a);
    wr(8'h03, 16'h0080);
    wr(8'h04, 16'h0001);
    wr(8'h02, 16'h00a5);
    ck(8'h80, 8'h5a);
    ck(8'h02, 8'ha5);
    wr(8'h01, 16'h0080);
    ck(8'h00, 8'h5a);
    wr(8'h04, 16'h0000);
    ck(8'h02, 8'h5a);
    wr(8'h80, 16'h1000);
    wr(8'h80, 16'h2600);
    ck(8'h80, 8'h1b);
    wr(8'h01, 16'h3000);
    ck(8'h01, 8'h81);
    wr(8'h01, 16'h4000);
    wr(8'h00, 16'h2000);
    ck(8'h80, 8'h1a);
    wr(8'h01, 16'h0002);
    wr(8'h00, 16'h0077);
    ck(8'h00, 8'h00);
    ck(8'h02, 8'h1a);
    wr(8'h40, 16'h0077);
    ck(8'h40, 8'h00);
    wr(8'h03, 16'h0040);
    wr(8'h04, 16'h0001);
    wr(8'h02, 16'h0077);
    ck(8'h02, 8'h77);
    ck(8'h40, 8'h00);
    wr(8'h03, 16'h0005);
    wr(8'h02, 16'h003c);
    ck(8'h05, 8'h3c);
    // Frozen clock enable ignores a core reset request
    clk_en <= 1'b0;
    req(1'b0);
    clk_en <= 1'b1;
    ck(8'h04, 8'h01);
    req(1'b1);
    ck(8'h04, 8'h01);
    req(1'b0);
    ck(8'h04, 8'h00);
    apb(1'b0, 32'h401, 32'h0);
    chk({31'h0, erv}, 32'h1);
    fork
      prog.frame(8'hc3, echo);
      begin
        repeat (30) @(posedge pclk);
        wr(8'h80, 16'h00ff);
        chk({31'h0, erv}, 32'h1);
      end
    join
    chk({24'h0, echo}, 32'hc3);
    wr(8'h08, 16'h0000);
    ck(8'h08, 8'hc3);
    ck(8'h80, 8'h1a);
    print_verdict();
  end
endmodule
`default_nettype wire
